//--- ahb_reg_port.sv
// AHB-Lite slave front end: address phase capture and one wait state
`timescale 1ns/1ps
module ahb_reg_port
	import irq_flag_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output reg_access_t      access
);

	typedef struct packed {
		bus_state_t  st;
		logic        ready;
		reg_access_t acc;
	} port_state_t;

	port_state_t s_reg;
	port_state_t s_next;

	always_comb begin
		s_next = s_reg;
		case (s_reg.st)
			BUS_IDLE: begin
				s_next.ready = 1'b1;
				s_next.acc.valid = 1'b0;
				if (hsel && htrans[HTRANS_ACTIVE_BIT] && hready) begin
					s_next.st = BUS_ACCESS;
					s_next.ready = 1'b0;
					s_next.acc.valid = 1'b1;
					s_next.acc.write = hwrite;
					s_next.acc.index = haddr[IDX_MSB:IDX_LSB];
				end
			end
			BUS_ACCESS: begin
				// Register file acts in this cycle; data leave on the next
				s_next.st = BUS_IDLE;
				s_next.ready = 1'b1;
				s_next.acc.valid = 1'b0;
			end
			default: begin
				s_next.st = BUS_IDLE;
				s_next.ready = 1'b1;
				s_next.acc.valid = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_reg.st <= BUS_IDLE;
			s_reg.ready <= 1'b1;
			s_reg.acc <= '0;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	assign hreadyout = s_reg.ready;
	assign hresp = HRESP_OKAY;
	assign access = s_reg.acc;

endmodule

//--- cpu_core_model.sv
// Behavioural core that services external requests by fetching the vector
`timescale 1ns/1ps
module cpu_core_model (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       ext_req,
	input  wire logic       take,
	input  wire logic [3:0] delay,
	input  wire logic       mask_in,
	output logic            cpu_imask,
	output logic            vec_fetch
);
	logic       in_service;
	logic [3:0] wait_cnt;

	// Stacking sets the mask, so a serviced request cannot re-enter
	assign cpu_imask = mask_in | in_service;

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			in_service <= 1'b0;
			wait_cnt   <= 4'h0;
			vec_fetch  <= 1'b0;
		end else begin
			vec_fetch <= 1'b0;
			if (!take) begin
				in_service <= 1'b0;
			end else if (ext_req && !in_service) begin
				if (wait_cnt == delay) begin
					vec_fetch  <= 1'b1;
					in_service <= 1'b1;
					wait_cnt   <= 4'h0;
				end else begin
					wait_cnt <= wait_cnt + 4'h1;
				end
			end
		end
	end
endmodule

//--- interrupt_flag_control.sv
// Interrupt flags, enables and request gating with an AHB-Lite register file
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module interrupt_flag_control
	import irq_flag_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        ARST_N,
	input  wire logic        CE,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	input  wire logic        IRQ_N,
	input  wire logic [3:0]  PA_IRQ,
	input  wire logic        PORT_A_INT_SOURCE_ENABLE,
	input  wire logic        LEVEL_TRIGGER,
	input  wire logic        CPU_IMASK,
	input  wire logic        VECTOR_FETCH_EXT,
	input  wire logic        CORE_OVF_EVENT,
	input  wire logic        REALTIME_EVENT,
	input  wire logic        CAPTURE_EVENT,
	input  wire logic        COMPARE_EVENT,
	input  wire logic        TIMER_OVF_EVENT,
	input  wire logic        SERIAL_DONE_EVENT,
	input  wire logic        CMP_ONE_EVENT,
	input  wire logic        CMP_TWO_EVENT,
	output logic             EXT_REQ,
	output logic             CORE_TIMER_REQ,
	output logic             PROG_TIMER_REQ,
	output logic             SERIAL_REQ,
	output logic             ANALOG_REQ,
	output logic             CAPTURE_TRIGGER,
	output logic             LPO_ENABLE,
	output logic             EPO_ENABLE,
	output logic             CLOCK_FROM_PIN
);

	typedef struct packed {
		logic        ext_en;
		logic        osc_high;
		logic        osc_low;
		logic        ext_flag;
		logic        core_ovf_flag;
		logic        rt_flag;
		logic        core_ovf_en;
		logic        rt_en;
		logic [1:0]  rt_rate;
		logic        cap_flag;
		logic        cmp_flag;
		logic        tmr_ovf_flag;
		logic        cap_arm;
		logic        cmp_arm;
		logic        ovf_arm;
		logic        ser_flag;
		logic        ser_en;
		logic        ser_arm;
		logic [7:0]  ser_data;
		logic        an_int_en;
		logic        an_cap_en;
		logic        c1_flag;
		logic        c2_flag;
		logic        irq_pin_q;
		logic [3:0]  pa_q;
		logic        ext_req;
		logic        core_req;
		logic        ptmr_req;
		logic        ser_req;
		logic        an_req;
		logic        cap_trig;
		osc_ctrl_t   osc;
		logic [31:0] rdata;
	} ctl_state_t;

	ctl_state_t  s_reg;
	ctl_state_t  s_next;
	timer_ctrl_t tcr_reg;
	timer_ctrl_t tcr_next;
	reg_access_t access;

	logic        wr;
	logic        rd;
	logic [7:0]  wd;
	logic        ext_event;
	logic        cap_set;
	logic        c2_set;

	ahb_reg_port u_port (
		.clk       (CLK),
		.arst_n    (ARST_N),
		.ce        (CE),
		.hsel      (HSEL),
		.haddr     (HADDR),
		.htrans    (HTRANS),
		.hwrite    (HWRITE),
		.hready    (HREADY),
		.hreadyout (HREADYOUT),
		.hresp     (HRESP),
		.access    (access)
	);

	always_comb begin
		wr = access.valid & access.write;
		rd = access.valid & ~access.write;
		wd = HWDATA[7:0];

		// Pin falls low or is held low; port lines rise or are held high
		ext_event = (LEVEL_TRIGGER ? ~IRQ_N : (s_reg.irq_pin_q & ~IRQ_N));
		if (PORT_A_INT_SOURCE_ENABLE) begin
			ext_event = ext_event | (LEVEL_TRIGGER ? (|PA_IRQ) :
				(|(PA_IRQ & ~s_reg.pa_q)));
		end

		c2_set = CMP_TWO_EVENT;
		cap_set = CAPTURE_EVENT | (c2_set & s_reg.an_cap_en);

		s_next = s_reg;
		tcr_next = tcr_reg;
		s_next.irq_pin_q = IRQ_N;
		s_next.pa_q = PA_IRQ;
		s_next.cap_trig = c2_set & s_reg.an_cap_en;

		// Software writes to control bits
		if (wr) begin
			case (access.index)
				IDX_EXTERNAL_IRQ_CTRL_REG: begin
					s_next.ext_en = wd[B_EXT_INT_ENABLE];
					s_next.osc_high = wd[B_OSC_SELECT_HIGH];
					s_next.osc_low = wd[B_OSC_SELECT_LOW];
				end
				IDX_CORE_TIMER_STATUS_CONTROL: begin
					s_next.core_ovf_en = wd[B_CORE_OVERFLOW_ENABLE];
					s_next.rt_en = wd[B_REALTIME_ENABLE];
					s_next.rt_rate = wd[B_RT_RATE_MSB:B_RT_RATE_LSB];
				end
				IDX_PROG_TIMER_CONTROL: begin
					tcr_next.cap_ie = wd[B_CAPTURE_INT_ENABLE];
					tcr_next.cmp_ie = wd[B_COMPARE_INT_ENABLE];
					tcr_next.ovf_ie = wd[B_TIMER_OVF_ENABLE];
					tcr_next.edge_sel = wd[B_CAPTURE_EDGE_SELECT];
				end
				IDX_SERIAL_CONTROL: begin
					s_next.ser_en = wd[B_SERIAL_INT_ENABLE];
				end
				IDX_SERIAL_DATA: begin
					s_next.ser_data = wd;
				end
				IDX_ANALOG_CONTROL: begin
					s_next.an_int_en = wd[B_COMPARATOR_INT_ENABLE];
					s_next.an_cap_en = wd[B_ANALOG_CAPTURE_TRIGGER];
				end
				default: begin
				end
			endcase
		end

		// Flag updates; each set outweighs a clear in the same cycle
		s_next.ext_flag = set_wins(s_reg.ext_flag, ext_event,
			VECTOR_FETCH_EXT | (wr &&
			access.index == IDX_EXTERNAL_IRQ_CTRL_REG &&
			wd[B_EXT_FLAG_CLEAR]));
		s_next.core_ovf_flag = set_wins(s_reg.core_ovf_flag, CORE_OVF_EVENT,
			wr && access.index == IDX_CORE_TIMER_STATUS_CONTROL &&
			wd[B_CORE_OVERFLOW_CLEAR]);
		s_next.rt_flag = set_wins(s_reg.rt_flag, REALTIME_EVENT,
			wr && access.index == IDX_CORE_TIMER_STATUS_CONTROL &&
			wd[B_REALTIME_FLAG_CLEAR]);

		// Status read arms the clear; a low byte access completes it, for capture a read only
		s_next.cap_flag = set_wins(s_reg.cap_flag, cap_set,
			s_reg.cap_arm && rd &&
			access.index == IDX_CAPTURE_LOW_BYTE);
		s_next.cmp_flag = set_wins(s_reg.cmp_flag, COMPARE_EVENT,
			s_reg.cmp_arm && access.valid &&
			access.index == IDX_COMPARE_LOW_BYTE);
		s_next.tmr_ovf_flag = set_wins(s_reg.tmr_ovf_flag, TIMER_OVF_EVENT,
			s_reg.ovf_arm && access.valid &&
			access.index == IDX_COUNTER_LOW_BYTE);
		if (rd && access.index == IDX_PROG_TIMER_STATUS) begin
			s_next.cap_arm = s_reg.cap_flag;
			s_next.cmp_arm = s_reg.cmp_flag;
			s_next.ovf_arm = s_reg.tmr_ovf_flag;
		end
		if (!s_next.cap_flag) begin
			s_next.cap_arm = 1'b0;
		end
		if (!s_next.cmp_flag) begin
			s_next.cmp_arm = 1'b0;
		end
		if (!s_next.tmr_ovf_flag) begin
			s_next.ovf_arm = 1'b0;
		end

		s_next.ser_flag = set_wins(s_reg.ser_flag, SERIAL_DONE_EVENT,
			(s_reg.ser_arm && access.valid &&
			access.index == IDX_SERIAL_DATA) ||
			(wr && access.index == IDX_SERIAL_CONTROL &&
			wd[B_SERIAL_FLAG_CLEAR]));
		if (rd && access.index == IDX_SERIAL_STATUS) begin
			s_next.ser_arm = s_reg.ser_flag;
		end
		if (!s_next.ser_flag) begin
			s_next.ser_arm = 1'b0;
		end

		s_next.c1_flag = set_wins(s_reg.c1_flag, CMP_ONE_EVENT,
			wr && access.index == IDX_ANALOG_STATUS &&
			wd[B_COMPARATOR_ONE_CLEAR]);
		s_next.c2_flag = set_wins(s_reg.c2_flag, c2_set,
			wr && access.index == IDX_ANALOG_STATUS &&
			wd[B_COMPARATOR_TWO_CLEAR]);

		// Requests toward the core, gated by enables and the global mask
		s_next.ext_req = s_reg.ext_flag & s_reg.ext_en & ~CPU_IMASK;
		s_next.core_req = ~CPU_IMASK &
			((s_reg.core_ovf_flag & s_reg.core_ovf_en) |
			(s_reg.rt_flag & s_reg.rt_en));
		s_next.ptmr_req = ~CPU_IMASK &
			((s_reg.cap_flag & tcr_reg.cap_ie) |
			(s_reg.cmp_flag & tcr_reg.cmp_ie) |
			(s_reg.tmr_ovf_flag & tcr_reg.ovf_ie));
		s_next.ser_req = ~CPU_IMASK &
			s_reg.ser_flag & s_reg.ser_en;
		s_next.an_req = ~CPU_IMASK & s_reg.an_int_en &
			(s_reg.c1_flag | s_reg.c2_flag);
		s_next.osc = osc_decode(s_reg.osc_high, s_reg.osc_low);

		// Read data; clear bits and unused positions read as zero
		s_next.rdata = READ_ZERO;
		if (rd) begin
			case (access.index)
				IDX_EXTERNAL_IRQ_CTRL_REG: begin
					s_next.rdata = place(place(place(place(READ_ZERO,
						B_EXT_INT_ENABLE, s_reg.ext_en),
						B_OSC_SELECT_HIGH, s_reg.osc_high),
						B_OSC_SELECT_LOW, s_reg.osc_low),
						B_EXT_INT_FLAG, s_reg.ext_flag);
				end
				IDX_CORE_TIMER_STATUS_CONTROL: begin
					s_next.rdata = place(place(place(place(READ_ZERO,
						B_OVERFLOW_FLAG, s_reg.core_ovf_flag),
						B_REALTIME_FLAG, s_reg.rt_flag),
						B_CORE_OVERFLOW_ENABLE, s_reg.core_ovf_en),
						B_REALTIME_ENABLE, s_reg.rt_en);
					s_next.rdata[B_RT_RATE_MSB:B_RT_RATE_LSB] = s_reg.rt_rate;
				end
				IDX_PROG_TIMER_CONTROL: begin
					s_next.rdata = place(place(place(place(READ_ZERO,
						B_CAPTURE_INT_ENABLE, tcr_reg.cap_ie),
						B_COMPARE_INT_ENABLE, tcr_reg.cmp_ie),
						B_TIMER_OVF_ENABLE, tcr_reg.ovf_ie),
						B_CAPTURE_EDGE_SELECT, tcr_reg.edge_sel);
				end
				IDX_PROG_TIMER_STATUS: begin
					s_next.rdata = place(place(place(READ_ZERO,
						B_CAPTURE_FLAG, s_reg.cap_flag),
						B_COMPARE_FLAG, s_reg.cmp_flag),
						B_TIMER_OVF_FLAG, s_reg.tmr_ovf_flag);
				end
				IDX_SERIAL_CONTROL: begin
					s_next.rdata = place(READ_ZERO,
						B_SERIAL_INT_ENABLE, s_reg.ser_en);
				end
				IDX_SERIAL_STATUS: begin
					s_next.rdata = place(READ_ZERO,
						B_SERIAL_TRANSFER_FLAG, s_reg.ser_flag);
				end
				IDX_SERIAL_DATA: begin
					s_next.rdata[7:0] = s_reg.ser_data;
				end
				IDX_ANALOG_CONTROL: begin
					s_next.rdata = place(place(READ_ZERO,
						B_COMPARATOR_INT_ENABLE, s_reg.an_int_en),
						B_ANALOG_CAPTURE_TRIGGER, s_reg.an_cap_en);
				end
				IDX_ANALOG_STATUS: begin
					s_next.rdata = place(place(READ_ZERO,
						B_COMPARATOR_TWO_FLAG, s_reg.c2_flag),
						B_COMPARATOR_ONE_FLAG, s_reg.c1_flag);
				end
				default: begin
					s_next.rdata = READ_ZERO;
				end
			endcase
		end else begin
			// Hold read data so it stands through the answering cycle
			s_next.rdata = s_reg.rdata;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			s_reg <= '0;
			s_reg.ext_en <= RST_EXT_INT_ENABLE;
			s_reg.osc_high <= RST_OSC_SELECT_HIGH;
			s_reg.osc_low <= RST_OSC_SELECT_LOW;
			s_reg.rt_rate <= RST_RT_RATE;
			s_reg.ser_data <= RST_SERIAL_DATA;
			s_reg.irq_pin_q <= RST_IRQ_PIN_IDLE;
			s_reg.pa_q <= RST_PA_IDLE;
			s_reg.osc <= osc_decode(RST_OSC_SELECT_HIGH,
				RST_OSC_SELECT_LOW);
			s_reg.rdata <= READ_ZERO;
		end else if (CE) begin
			s_reg <= s_next;
		end
	end

	// Left out of reset on purpose; reads unknown until software writes it
	always_ff @(posedge CLK) begin
		if (CE) begin
			tcr_reg <= tcr_next;
		end
	end

	assign HRDATA = s_reg.rdata;
	assign EXT_REQ = s_reg.ext_req;
	assign CORE_TIMER_REQ = s_reg.core_req;
	assign PROG_TIMER_REQ = s_reg.ptmr_req;
	assign SERIAL_REQ = s_reg.ser_req;
	assign ANALOG_REQ = s_reg.an_req;
	assign CAPTURE_TRIGGER = s_reg.cap_trig;
	assign LPO_ENABLE = s_reg.osc.lpo_en;
	assign EPO_ENABLE = s_reg.osc.epo_en;
	assign CLOCK_FROM_PIN = s_reg.osc.pin_clk;

endmodule

//--- interrupt_flag_control_tb.sv
// Self-checking bench for the interrupt flag block
`timescale 1ns/1ps
module interrupt_flag_control_tb;
	import irq_flag_pkg::*;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rdv;
	logic        hreadyout, hresp, cpu_imask, vec_fetch;
	logic        irq_n = 1'b1;
	logic [3:0]  pa_irq = 4'h0;
	logic [3:0]  delay = 4'h0;
	logic        pa_en = 1'b0;
	logic        imask_req = 1'b0;
	logic        take = 1'b0;
	logic        lvl = 1'b0;
	logic [7:0]  ev = 8'h00;
	logic        ext_req, core_req, prog_req, ser_req, an_req;
	logic        cap_trig, internal_low_power_osc, pin_oscillator, pin_clk;
	int          n_mismatch = 0;
	int          num_checks = 0;

	always #25 clk = ~clk;

	interrupt_flag_control u_dut (
		.CLK(clk), .ARST_N(arst_n), .CE(1'b1), .HSEL(hsel),
		.HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
		.HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
		.HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
		.IRQ_N(irq_n), .PA_IRQ(pa_irq), .PORT_A_INT_SOURCE_ENABLE(pa_en),
		.LEVEL_TRIGGER(lvl), .CPU_IMASK(cpu_imask),
		.VECTOR_FETCH_EXT(vec_fetch), .CORE_OVF_EVENT(ev[0]),
		.REALTIME_EVENT(ev[1]), .CAPTURE_EVENT(ev[2]),
		.COMPARE_EVENT(ev[3]), .TIMER_OVF_EVENT(ev[4]),
		.SERIAL_DONE_EVENT(ev[5]), .CMP_ONE_EVENT(ev[6]),
		.CMP_TWO_EVENT(ev[7]), .EXT_REQ(ext_req),
		.CORE_TIMER_REQ(core_req), .PROG_TIMER_REQ(prog_req),
		.SERIAL_REQ(ser_req), .ANALOG_REQ(an_req),
		.CAPTURE_TRIGGER(cap_trig), .LPO_ENABLE(internal_low_power_osc),
		.EPO_ENABLE(pin_oscillator), .CLOCK_FROM_PIN(pin_clk)
	);

	cpu_core_model u_cpu (
		.clk(clk), .arst_n(arst_n), .ext_req(ext_req), .take(take),
		.delay(delay), .mask_in(imask_req), .cpu_imask(cpu_imask),
		.vec_fetch(vec_fetch)
	);

	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Ready is read in the active region, so it is the pre-edge value
	task automatic bus(input logic wr, input logic [5:0] idx,
		input logic [7:0] wd);
		@(posedge clk);
		hsel   <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr  <= {24'h0, idx, 2'h0};
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do @(posedge clk); while (hreadyout !== 1'b1);
		rdv = hrdata;
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
	endtask

	task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 8'h00);
		chk(rdv, exp);
	endtask

	task automatic pulse(input int i);
		@(posedge clk);
		ev[i] <= 1'b1;
		@(posedge clk);
		ev <= 8'h00;
		repeat (2) @(posedge clk);
	endtask

	task automatic irq_fall;
		@(posedge clk);
		irq_n <= 1'b0;
		@(posedge clk);
		irq_n <= 1'b1;
		repeat (2) @(posedge clk);
	endtask

	task automatic t_reset;
		rdc(IDX_EXTERNAL_IRQ_CTRL_REG, 32'h0000_00C0);
		chk({internal_low_power_osc, pin_oscillator, pin_clk}, 3'h4);
		rdc(IDX_CORE_TIMER_STATUS_CONTROL, 32'h0000_0003);
		rdc(IDX_ANALOG_STATUS, 32'h0);
		rdc(6'h3F, 32'h0);
	endtask

	task automatic t_osc;
		logic [2:0] exp_o [4] = '{3'h4, 3'h3, 3'h4, 3'h6};
		for (int v = 0; v < 4; v++) begin
			wr(IDX_EXTERNAL_IRQ_CTRL_REG, {1'b1, v[1:0], 5'h1F});
			@(posedge clk);
			chk({internal_low_power_osc, pin_oscillator, pin_clk}, exp_o[v]);
			rdc(IDX_EXTERNAL_IRQ_CTRL_REG, {24'h0, 1'b1, v[1:0], 5'h0});
		end
		wr(IDX_EXTERNAL_IRQ_CTRL_REG, 8'hC0);
	endtask

	task automatic t_ext;
		irq_fall();
		rdc(IDX_EXTERNAL_IRQ_CTRL_REG, 32'h0000_00C8);
		chk(ext_req, 1'b1);
		imask_req <= 1'b1;
		repeat (3) @(posedge clk);
		chk(ext_req, 1'b0);
		wr(IDX_EXTERNAL_IRQ_CTRL_REG, 8'hC0);
		rdc(IDX_EXTERNAL_IRQ_CTRL_REG, 32'h0000_00C8);
		wr(IDX_EXTERNAL_IRQ_CTRL_REG, 8'hC2);
		rdc(IDX_EXTERNAL_IRQ_CTRL_REG, 32'h0000_00C0);
		imask_req <= 1'b0;
		wr(IDX_EXTERNAL_IRQ_CTRL_REG, 8'h40);
		irq_fall();
		rdc(IDX_EXTERNAL_IRQ_CTRL_REG, 32'h0000_0048);
		chk(ext_req, 1'b0);
		take  <= 1'b1;
		delay <= 4'h5;
		wr(IDX_EXTERNAL_IRQ_CTRL_REG, 8'hC0);
		repeat (12) @(posedge clk);
		rdc(IDX_EXTERNAL_IRQ_CTRL_REG, 32'h0000_00C0);
		take  <= 1'b0;
		pa_irq <= 4'h8;
		repeat (3) @(posedge clk);
		pa_irq <= 4'h0;
		rdc(IDX_EXTERNAL_IRQ_CTRL_REG, 32'h0000_00C0);
		pa_en  <= 1'b1;
		pa_irq <= 4'h8;
		repeat (3) @(posedge clk);
		pa_irq <= 4'h0;
		rdc(IDX_EXTERNAL_IRQ_CTRL_REG, 32'h0000_00C8);
		take  <= 1'b1;
		delay <= 4'h0;
		repeat (6) @(posedge clk);
		rdc(IDX_EXTERNAL_IRQ_CTRL_REG, 32'h0000_00C0);
		take <= 1'b0;
		// Level mode: a pin held low re-sets the flag over a clear
		lvl   <= 1'b1;
		irq_n <= 1'b0;
		wr(IDX_EXTERNAL_IRQ_CTRL_REG, 8'hC2);
		rdc(IDX_EXTERNAL_IRQ_CTRL_REG, 32'h0000_00C8);
		lvl   <= 1'b0;
		irq_n <= 1'b1;
		wr(IDX_EXTERNAL_IRQ_CTRL_REG, 8'hC2);
		rdc(IDX_EXTERNAL_IRQ_CTRL_REG, 32'h0000_00C0);
	endtask

	task automatic t_core;
		wr(IDX_CORE_TIMER_STATUS_CONTROL, 8'h33);
		pulse(0);
		chk(core_req, 1'b1);
		rdc(IDX_CORE_TIMER_STATUS_CONTROL, 32'h0000_00B3);
		wr(IDX_CORE_TIMER_STATUS_CONTROL, 8'h3B);
		rdc(IDX_CORE_TIMER_STATUS_CONTROL, 32'h0000_0033);
		chk(core_req, 1'b0);
		pulse(1);
		chk(core_req, 1'b1);
		wr(IDX_CORE_TIMER_STATUS_CONTROL, 8'h37);
		rdc(IDX_CORE_TIMER_STATUS_CONTROL, 32'h0000_0033);
		// Event lands in the very cycle the clear is written
		fork
			wr(IDX_CORE_TIMER_STATUS_CONTROL, 8'h3B);
			begin
				repeat (2) @(posedge clk);
				ev[0] <= 1'b1;
				@(posedge clk);
				ev[0] <= 1'b0;
			end
		join
		rdc(IDX_CORE_TIMER_STATUS_CONTROL, 32'h0000_00B3);
		wr(IDX_CORE_TIMER_STATUS_CONTROL, 8'h0B);
	endtask

	task automatic t_serial;
		wr(IDX_SERIAL_CONTROL, 8'h80);
		pulse(5);
		chk(ser_req, 1'b1);
		rdc(IDX_SERIAL_STATUS, 32'h0000_0080);
		wr(IDX_SERIAL_DATA, 8'h5A);
		rdc(IDX_SERIAL_STATUS, 32'h0);
		rdc(IDX_SERIAL_DATA, 32'h0000_005A);
		pulse(5);
		wr(IDX_SERIAL_CONTROL, 8'hC0);
		rdc(IDX_SERIAL_STATUS, 32'h0);
		chk(ser_req, 1'b0);
	endtask

	task automatic t_analog;
		wr(IDX_ANALOG_CONTROL, 8'h80);
		pulse(6);
		chk(an_req, 1'b1);
		imask_req <= 1'b1;
		repeat (3) @(posedge clk);
		chk(an_req, 1'b0);
		imask_req <= 1'b0;
		rdc(IDX_ANALOG_STATUS, 32'h0000_0040);
		wr(IDX_ANALOG_STATUS, 8'h10);
		rdc(IDX_ANALOG_STATUS, 32'h0);
		pulse(7);
		rdc(IDX_ANALOG_STATUS, 32'h0000_0080);
		wr(IDX_ANALOG_STATUS, 8'h20);
		rdc(IDX_ANALOG_STATUS, 32'h0);
	endtask

	task automatic t_timer;
		wr(IDX_PROG_TIMER_CONTROL, 8'hE2);
		rdc(IDX_PROG_TIMER_CONTROL, 32'h0000_00E2);
		pulse(2);
		chk(prog_req, 1'b1);
		rdc(IDX_CAPTURE_LOW_BYTE, 32'h0);
		rdc(IDX_PROG_TIMER_STATUS, 32'h0000_0080);
		wr(IDX_CAPTURE_LOW_BYTE, 8'h00);
		rdc(IDX_PROG_TIMER_STATUS, 32'h0000_0080);
		rdc(IDX_CAPTURE_LOW_BYTE, 32'h0);
		rdc(IDX_PROG_TIMER_STATUS, 32'h0);
		pulse(3);
		rdc(IDX_PROG_TIMER_STATUS, 32'h0000_0040);
		wr(IDX_COMPARE_LOW_BYTE, 8'h00);
		rdc(IDX_PROG_TIMER_STATUS, 32'h0);
		pulse(4);
		rdc(IDX_PROG_TIMER_STATUS, 32'h0000_0020);
		rdc(IDX_COUNTER_LOW_BYTE, 32'h0);
		rdc(IDX_PROG_TIMER_STATUS, 32'h0);
		chk(prog_req, 1'b0);
		wr(IDX_ANALOG_CONTROL, 8'h40);
		@(posedge clk);
		ev[7] <= 1'b1;
		@(posedge clk);
		ev <= 8'h00;
		@(posedge clk);
		chk(cap_trig, 1'b1);
		repeat (2) @(posedge clk);
		rdc(IDX_PROG_TIMER_STATUS, 32'h0000_0080);
		chk(prog_req, 1'b1);
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		rdc(IDX_PROG_TIMER_CONTROL, 32'h0000_00E2);
		rdc(IDX_PROG_TIMER_STATUS, 32'h0);
		rdc(IDX_ANALOG_STATUS, 32'h0);
		rdc(IDX_EXTERNAL_IRQ_CTRL_REG, 32'h0000_00C0);
	endtask

	initial begin
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_osc();
		t_ext();
		t_core();
		t_serial();
		t_analog();
		t_timer();
		results();
	end

	initial begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		results();
	end
endmodule

//--- irq_flag_pkg.sv
// Register map, field layout, types and helpers of the interrupt flag block
package irq_flag_pkg;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_CORE_TIMER_STATUS_CONTROL = 6'h08;
	localparam logic [5:0] IDX_SERIAL_CONTROL            = 6'h0A;
	localparam logic [5:0] IDX_SERIAL_STATUS             = 6'h0B;
	localparam logic [5:0] IDX_SERIAL_DATA               = 6'h0C;
	localparam logic [5:0] IDX_PROG_TIMER_CONTROL        = 6'h12;
	localparam logic [5:0] IDX_PROG_TIMER_STATUS         = 6'h13;
	localparam logic [5:0] IDX_ANALOG_CONTROL            = 6'h1D;
	localparam logic [5:0] IDX_ANALOG_STATUS             = 6'h1E;
	localparam logic [5:0] IDX_EXTERNAL_IRQ_CTRL_REG     = 6'h1F;
	localparam logic [5:0] IDX_CAPTURE_LOW_BYTE          = 6'h20;
	localparam logic [5:0] IDX_COMPARE_LOW_BYTE          = 6'h21;
	localparam logic [5:0] IDX_COUNTER_LOW_BYTE          = 6'h22;

	// Word address bits that carry the index
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = 7;

	// External interrupt control register
	localparam int B_EXT_INT_ENABLE    = 7;
	localparam int B_OSC_SELECT_HIGH   = 6;
	localparam int B_OSC_SELECT_LOW    = 5;
	localparam int B_EXT_INT_FLAG      = 3;
	localparam int B_EXT_FLAG_CLEAR    = 1;

	// Core timer status and control
	localparam int B_OVERFLOW_FLAG        = 7;
	localparam int B_REALTIME_FLAG        = 6;
	localparam int B_CORE_OVERFLOW_ENABLE = 5;
	localparam int B_REALTIME_ENABLE      = 4;
	localparam int B_CORE_OVERFLOW_CLEAR  = 3;
	localparam int B_REALTIME_FLAG_CLEAR  = 2;
	localparam int B_RT_RATE_MSB          = 1;
	localparam int B_RT_RATE_LSB          = 0;

	// Programmable timer control and status
	localparam int B_CAPTURE_INT_ENABLE  = 7;
	localparam int B_COMPARE_INT_ENABLE  = 6;
	localparam int B_TIMER_OVF_ENABLE    = 5;
	localparam int B_CAPTURE_EDGE_SELECT = 1;
	localparam int B_CAPTURE_FLAG        = 7;
	localparam int B_COMPARE_FLAG        = 6;
	localparam int B_TIMER_OVF_FLAG      = 5;

	// Serial control and status
	localparam int B_SERIAL_INT_ENABLE    = 7;
	localparam int B_SERIAL_FLAG_CLEAR    = 6;
	localparam int B_SERIAL_TRANSFER_FLAG = 7;

	// Analog control and status
	localparam int B_COMPARATOR_INT_ENABLE  = 7;
	localparam int B_ANALOG_CAPTURE_TRIGGER = 6;
	localparam int B_COMPARATOR_TWO_FLAG    = 7;
	localparam int B_COMPARATOR_ONE_FLAG    = 6;
	localparam int B_COMPARATOR_TWO_CLEAR   = 5;
	localparam int B_COMPARATOR_ONE_CLEAR   = 4;

	// Reset values
	localparam logic       RST_EXT_INT_ENABLE  = 1'b1;
	localparam logic       RST_OSC_SELECT_HIGH = 1'b1;
	localparam logic       RST_OSC_SELECT_LOW  = 1'b0;
	localparam logic [1:0] RST_RT_RATE         = 2'h3;
	localparam logic [7:0] RST_SERIAL_DATA     = 8'h00;
	localparam logic       RST_IRQ_PIN_IDLE    = 1'b1;
	localparam logic [3:0] RST_PA_IDLE         = 4'h0;
	localparam logic [31:0] READ_ZERO          = 32'h0000_0000;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam int         HTRANS_ACTIVE_BIT = 1;
	localparam logic       HRESP_OKAY = 1'b0;

	typedef enum logic {
		BUS_IDLE,
		BUS_ACCESS
	} bus_state_t;

	// Register access strobe handed from the bus port to the register file
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [5:0] index;
	} reg_access_t;

	typedef struct packed {
		logic lpo_en;
		logic epo_en;
		logic pin_clk;
	} osc_ctrl_t;

	typedef struct packed {
		logic cap_ie;
		logic cmp_ie;
		logic ovf_ie;
		logic edge_sel;
	} timer_ctrl_t;

	// A new event outweighs a clear arriving in the same cycle
	function automatic logic set_wins(input logic flag, input logic set,
		input logic clr);
		return set | (flag & ~clr);
	endfunction

	function automatic osc_ctrl_t osc_decode(input logic high,
		input logic low);
		osc_ctrl_t o;
		o.lpo_en  = ~low | high;
		o.epo_en  = low;
		o.pin_clk = low & ~high;
		return o;
	endfunction

	function automatic logic [31:0] place(input logic [31:0] word,
		input int pos, input logic b);
		logic [31:0] w;
		w = word;
		w[pos] = b;
		return w;
	endfunction

endpackage

//--- irq_flag_properties.sv
// Concurrent checks on the ports of the interrupt flag block
`timescale 1ns/1ps
module irq_flag_properties
	import irq_flag_pkg::*;
(
	input wire logic       CLK,
	input wire logic       ARST_N,
	input wire logic       CE,
	input wire logic       HSEL,
	input wire logic [1:0] HTRANS,
	input wire logic       HREADY,
	input wire logic       HREADYOUT,
	input wire logic       HRESP,
	input wire logic       IRQ_N,
	input wire logic [3:0] PA_IRQ,
	input wire logic       PORT_A_INT_SOURCE_ENABLE,
	input wire logic       CPU_IMASK,
	input wire logic       VECTOR_FETCH_EXT,
	input wire logic       CMP_TWO_EVENT,
	input wire logic       EXT_REQ,
	input wire logic       CORE_TIMER_REQ,
	input wire logic       PROG_TIMER_REQ,
	input wire logic       SERIAL_REQ,
	input wire logic       ANALOG_REQ,
	input wire logic       CAPTURE_TRIGGER,
	input wire logic       LPO_ENABLE,
	input wire logic       EPO_ENABLE,
	input wire logic       CLOCK_FROM_PIN
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);

	sequence addr_taken;
		CE && HSEL && HTRANS[1] && HREADY && HREADYOUT;
	endsequence
	sequence one_wait;
		!HREADYOUT ##1 HREADYOUT;
	endsequence
	// No new edge on either source, so nothing may re-set the flag
	sequence quiet_fetch;
		VECTOR_FETCH_EXT && IRQ_N &&
			(!PORT_A_INT_SOURCE_ENABLE || PA_IRQ == 4'h0);
	endsequence

	AST_WAIT_STATE: assert property (addr_taken |=> one_wait)
		else $error("bus answer not after one wait state");
	AST_READY_LOW_ONCE: assert property (!HREADYOUT |=> HREADYOUT)
		else $error("ready held low over two cycles");
	AST_HRESP_OKAY: assert property (HRESP == HRESP_OKAY)
		else $error("bus response not okay");
	AST_OSC_DECODE: assert property (
		(CLOCK_FROM_PIN == (EPO_ENABLE && !LPO_ENABLE)) &&
		(LPO_ENABLE || EPO_ENABLE))
		else $error("oscillator outputs inconsistent");
	AST_MASK_BLOCKS: assert property ($past(CPU_IMASK) |->
		!(CORE_TIMER_REQ || PROG_TIMER_REQ || SERIAL_REQ || ANALOG_REQ))
		else $error("request passed a set global mask");
	AST_EXT_GATED: assert property (EXT_REQ |-> !$past(CPU_IMASK))
		else $error("external request with mask set");
	AST_TRIGGER_CAUSE: assert property (
		CAPTURE_TRIGGER |-> $past(CMP_TWO_EVENT))
		else $error("capture trigger without comparator event");
	AST_VEC_CLEAR: assert property (quiet_fetch |-> ##2 !EXT_REQ)
		else $error("vector fetch left external request up");
endmodule

bind interrupt_flag_control irq_flag_properties u_props (
	.CLK(CLK), .ARST_N(ARST_N), .CE(CE), .HSEL(HSEL),
	.HTRANS(HTRANS), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
	.HRESP(HRESP), .IRQ_N(IRQ_N), .PA_IRQ(PA_IRQ),
	.PORT_A_INT_SOURCE_ENABLE(PORT_A_INT_SOURCE_ENABLE),
	.CPU_IMASK(CPU_IMASK), .VECTOR_FETCH_EXT(VECTOR_FETCH_EXT),
	.CMP_TWO_EVENT(CMP_TWO_EVENT), .EXT_REQ(EXT_REQ),
	.CORE_TIMER_REQ(CORE_TIMER_REQ), .PROG_TIMER_REQ(PROG_TIMER_REQ),
	.SERIAL_REQ(SERIAL_REQ), .ANALOG_REQ(ANALOG_REQ),
	.CAPTURE_TRIGGER(CAPTURE_TRIGGER), .LPO_ENABLE(LPO_ENABLE),
	.EPO_ENABLE(EPO_ENABLE), .CLOCK_FROM_PIN(CLOCK_FROM_PIN)
);
